// ---- bench/itd_phase_model.sv ----
// Phase current source that strobes one good sample every third cycle
`timescale 1ns/1ps
module itd_phase_model (
    input logic clk_sys,
    input logic [15:0] amp_a,
    input logic [15:0] amp_b,
    input logic [15:0] amp_c,
    output logic [15:0] phase_a_cur,
    output logic [15:0] phase_b_cur,
    output logic [15:0] phase_c_cur,
    output logic cur_valid
);
    logic [1:0] cnt_q;
    logic hit;
    assign hit = (cnt_q == 2'h2);
    initial begin
        cnt_q = 2'h0;
        cur_valid = 1'b0;
        {phase_a_cur, phase_b_cur, phase_c_cur} = '0;
    end
    // Lines carry the inverse off the strobe, so a stray sample shows up
    always @(posedge clk_sys) begin
        cnt_q <= hit ? 2'h0 : cnt_q + 2'h1;
        cur_valid <= hit;
        phase_a_cur <= hit ? amp_a : ~amp_a;
        phase_b_cur <= hit ? amp_b : ~amp_b;
        phase_c_cur <= hit ? amp_c : ~amp_c;
    end
endmodule

// ---- bench/itd_trip_assertions.sv ----
// Port-level checks for the overcurrent trip block
`timescale 1ns/1ps
module itd_trip_assertions (
    input logic clk_sys,
    input logic reset_n,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic tick_1s,
    input logic trip_alarm,
    input logic trip_loaddump,
    input logic trip_shutdown,
    input logic overcurrent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_alarm_excl: assert property (!(trip_loaddump && trip_shutdown))
        else $error("both trip actions active");
    chk_action_out: assert property ($rose(trip_alarm) |-> ##[0:1] (trip_loaddump || trip_shutdown))
        else $error("trip without action output");
    chk_trip_sticky: assert property ($fell(trip_alarm) |-> $rose(s_axi_bvalid))
        else $error("trip dropped without a write");
    chk_trip_on_tick: assert property ($rose(trip_alarm) |-> $past(tick_1s) || $past(tick_1s, 2))
        else $error("trip not after a tick");
    chk_trip_over: assert property ($rose(trip_alarm) |-> overcurrent)
        else $error("trip while not over limit");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule
bind itd_trip itd_trip_assertions u_chk (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tick_1s, .trip_alarm,
    .trip_loaddump, .trip_shutdown, .overcurrent);

// ---- bench/itd_trip_tb.sv ----
// Self-checking bench for the overcurrent trip block
`timescale 1ns/1ps
module itd_trip_tb;
    logic clk_sys, reset_n, tick_1s, cur_valid, s_axi_bready, s_axi_rready;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, tcnt;
    logic [15:0] phase_a_cur, phase_b_cur, phase_c_cur, amp_a, amp_b, amp_c;
    logic trip_alarm, trip_loaddump, trip_shutdown, overcurrent;
    int n_mismatch = 0;
    int checks = 0;
    itd_trip uut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .phase_a_cur, .phase_b_cur, .phase_c_cur, .cur_valid, .tick_1s,
        .trip_alarm, .trip_loaddump, .trip_shutdown, .overcurrent);
    itd_phase_model u_src (.clk_sys, .amp_a, .amp_b, .amp_c, .phase_a_cur, .phase_b_cur,
        .phase_c_cur, .cur_valid);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        n_mismatch++;
        print_verdict;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 50) tmo;
        check(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 50) tmo;
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic set_amps(input logic [15:0] cur, input int pos);
        amp_a <= (pos == 0) ? cur : 16'h0014;
        amp_b <= (pos == 1) ? cur : 16'h0014;
        amp_c <= (pos == 2) ? cur : 16'h0014;
    endtask
    task automatic wait_trip(output int n);
        int k;
        n = 0;
        for (k = 0; k < 20000; k++) begin
            @(posedge clk_sys);
            if (trip_alarm) break;
            if (tick_1s) n++;
        end
        if (k == 20000) tmo;
    endtask
    task automatic rearm(input logic [31:0] ctrl);
        set_amps(16'h0014, 0);
        // Disable first: a live trip condition would win over the clear
        wr(itd_pkg::ITD_OFS_CTRL, 32'h0000_0000, 2'h0);
        wr(itd_pkg::ITD_OFS_CTRL, 32'h0000_0100, 2'h0);
        wr(itd_pkg::ITD_OFS_CTRL, ctrl, 2'h0);
    endtask
    task automatic t_regs;
        rd(itd_pkg::ITD_OFS_CTRL, 32'h0000_0001, 2'h0);
        rd(itd_pkg::ITD_OFS_LIM_PRI, 32'h0000_FFFF, 2'h0);
        rd(itd_pkg::ITD_OFS_TMS, 32'h0000_0024, 2'h0);
        rd(itd_pkg::ITD_OFS_COOL, 32'h0000_0001, 2'h0);
        rd(8'h40, 32'h0000_0000, 2'h2);
        wr(itd_pkg::ITD_OFS_STATUS, 32'h0000_0001, 2'h2);
        wr(itd_pkg::ITD_OFS_LIM_PRI, 32'h0000_0064, 2'h0);
        wr(itd_pkg::ITD_OFS_LIM_SEC, 32'h0000_0032, 2'h0);
        wr(itd_pkg::ITD_OFS_LIM_TER, 32'h0000_0019, 2'h0);
        $display("register test done");
    endtask
    task automatic t_idle;
        rearm(32'h0000_0001);
        set_amps(16'h0064, 1);
        repeat (1200) @(posedge clk_sys);
        check(32'(overcurrent), 32'h0);
        check(32'(trip_alarm), 32'h0);
        $display("at-limit test done");
    endtask
    task automatic run_trip(input logic [31:0] ctrl, input int lim, input logic [15:0] cur,
        input int pos);
        int n, ex, exp;
        ex = int'(cur) - lim;
        if (ex > 2 * lim) ex = 2 * lim;
        exp = int'(itd_pkg::ITD_RST_TMS) * lim * lim / (ex * ex);
        rearm(ctrl);
        set_amps(cur, pos);
        wait_trip(n);
        check(32'(n >= exp - 1 && n <= exp + 1), 32'h1);
        @(posedge clk_sys);
        check(32'(trip_shutdown), 32'(ctrl[1]));
        check(32'(trip_loaddump), 32'(!ctrl[1]));
        check(32'(overcurrent), 32'h1);
        rd(itd_pkg::ITD_OFS_STATUS, ctrl[1] ? 32'h0000_000D : 32'h0000_000B, 2'h0);
        rd(itd_pkg::ITD_OFS_IMAX, {16'h0000, cur}, 2'h0);
    endtask
    task automatic t_curve;
        run_trip(32'h0000_0001, 100, 16'h006E, 0);
        run_trip(32'h0000_0003, 100, 16'h00C8, 1);
        run_trip(32'h0000_0001, 100, 16'h012C, 2);
        run_trip(32'h0000_0003, 100, 16'h0190, 0);
        run_trip(32'h0000_0005, 50, 16'h0064, 1);
        run_trip(32'h0000_000B, 25, 16'h0064, 2);
        $display("trip curve test done");
    endtask
    task automatic t_heat(input logic [31:0] cool, input int lo, input int hi);
        int n;
        rearm(32'h0000_0000);
        wr(itd_pkg::ITD_OFS_COOL, cool, 2'h0);
        wr(itd_pkg::ITD_OFS_CTRL, 32'h0000_0001, 2'h0);
        set_amps(16'h00C8, 0);
        repeat (80) @(posedge clk_sys);
        set_amps(16'h0014, 0);
        repeat (100) @(posedge clk_sys);
        set_amps(16'h00C8, 0);
        wait_trip(n);
        check(32'(n >= lo && n <= hi), 32'h1);
        $display("residual heat test done");
    endtask
    always @(posedge clk_sys) begin
        tcnt <= tcnt + 2'h1;
        tick_1s <= (tcnt == 2'h3);
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        reset_n = 1'b0;
        {tcnt, tick_1s, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {amp_a, amp_b, amp_c} = '0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs;
        t_idle;
        t_curve;
        t_heat(32'h0000_0001, 13, 19);
        t_heat(32'h0001_0000, 35, 38);
        print_verdict;
    end
endmodule

// ---- inc/itd_calc_if.sv ----
// Signals between the register side and the heat integrator
`timescale 1ns/1ps
interface itd_calc_if;
    logic enable;
    logic tick;
    logic sample;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic [15:0] limit;
    logic [15:0] tms;
    logic [31:0] cool;
    logic [15:0] imax;
    logic over;
    logic reached;
    logic [47:0] heat;
    modport engine (
        input enable, tick, sample, cur_a, cur_b, cur_c, limit, tms, cool,
        output imax, over, reached, heat
    );
    modport ctrl (
        output enable, tick, sample, cur_a, cur_b, cur_c, limit, tms, cool,
        input imax, over, reached, heat
    );
endinterface

// ---- inc/itd_pkg.sv ----
// Constants and types for the inverse-time overcurrent trip block
package itd_pkg;
    localparam logic [7:0] ITD_OFS_CTRL = 8'h00;
    localparam logic [7:0] ITD_OFS_LIM_PRI = 8'h04;
    localparam logic [7:0] ITD_OFS_LIM_SEC = 8'h08;
    localparam logic [7:0] ITD_OFS_LIM_TER = 8'h0C;
    localparam logic [7:0] ITD_OFS_TMS = 8'h10;
    localparam logic [7:0] ITD_OFS_COOL = 8'h14;
    localparam logic [7:0] ITD_OFS_STATUS = 8'h18;
    localparam logic [7:0] ITD_OFS_IMAX = 8'h1C;
    localparam logic [7:0] ITD_OFS_HEAT = 8'h20;

    localparam int ITD_CTRL_EN_BIT = 0;
    localparam int ITD_CTRL_ACT_BIT = 1;
    localparam int ITD_CTRL_SET_LO = 2;
    localparam int ITD_CTRL_CLR_BIT = 8;

    localparam int ITD_STAT_TRIP_BIT = 0;
    localparam int ITD_STAT_DUMP_BIT = 1;
    localparam int ITD_STAT_SHUT_BIT = 2;
    localparam int ITD_STAT_OVER_BIT = 3;

    localparam logic ITD_RST_EN = 1'b1;
    localparam logic ITD_RST_ACT = 1'b0;
    localparam logic [15:0] ITD_RST_LIMIT = 16'hFFFF;
    localparam logic [15:0] ITD_RST_TMS = 16'h0024;
    localparam logic [31:0] ITD_RST_COOL = 32'h0000_0001;

    // Overload excess is clamped at limit << shift, i.e. 300% load
    localparam int ITD_MAX_OVER_SHIFT = 1;

    localparam logic [1:0] ITD_RESP_OKAY = 2'h0;
    localparam logic [1:0] ITD_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ITD_SET_PRI = 2'b00,
        ITD_SET_SEC = 2'b01,
        ITD_SET_TER = 2'b10
    } itd_rating_t;
endpackage

// ---- logic/itd_heat.sv ----
// Heat integrator: worst phase, squared overload, accumulate and cool
`timescale 1ns/1ps
module itd_heat (
    input wire logic clk_sys,
    input wire logic reset_n,
    itd_calc_if.engine calc
);
    logic [15:0] imax_q;
    logic [47:0] acc_q;
    logic [47:0] thr;
    logic [16:0] diff_cap;
    logic [16:0] diff_raw;
    logic [15:0] diff;
    logic [31:0] sq;
    logic [47:0] sum;
    logic [15:0] max_ab;

    assign max_ab = (calc.cur_a > calc.cur_b) ? calc.cur_a : calc.cur_b;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            imax_q <= 16'h0000;
        end else if (calc.sample) begin
            imax_q <= (max_ab > calc.cur_c) ? max_ab : calc.cur_c;
        end
    end

    // Relative overload squared is (I - Ilim)^2 / Ilim^2; the divide moves to the threshold
    assign diff_raw = {1'b0, imax_q} - {1'b0, calc.limit};
    assign diff_cap = {1'b0, calc.limit} << itd_pkg::ITD_MAX_OVER_SHIFT;
    assign diff = (diff_raw > diff_cap) ? diff_cap[15:0] : diff_raw[15:0];
    assign sq = diff * diff;
    // One unit of heat equals TMS seconds of 100% overload
    assign thr = calc.tms * calc.limit * calc.limit;
    assign sum = acc_q + {16'h0000, sq};

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !calc.enable) begin
            acc_q <= 48'h0000_0000_0000;
        end else if (calc.tick) begin
            if (imax_q > calc.limit) begin
                // Capped at one unit so the sum cannot wrap while tripped
                acc_q <= (sum > thr) ? thr : sum;
            end else if (acc_q > {16'h0000, calc.cool}) begin
                acc_q <= acc_q - {16'h0000, calc.cool};
            end else begin
                acc_q <= 48'h0000_0000_0000;
            end
        end
    end

    assign calc.imax = imax_q;
    assign calc.over = imax_q > calc.limit;
    assign calc.reached = acc_q >= thr;
    assign calc.heat = acc_q;
endmodule

// ---- logic/itd_trip.sv ----
// Inverse-time overcurrent trip: AXI4-Lite registers, rating sets, trip alarm
// Behaviour
// - Delay is TMS over squared overload excess
// - Use the most loaded phase current
// - TMS equals delay at 100% overload
// - Never trip at or below the limit
// - Clamp delay at a definite minimum
// - Keep residual heat after non-tripping overload
// - Three rating sets each with own limit
// - Trip action: load dump or shutdown
// - TMS 36 gives 3600s, 36s, 9s
`timescale 1ns/1ps
module itd_trip (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] phase_a_cur,
    input wire logic [15:0] phase_b_cur,
    input wire logic [15:0] phase_c_cur,
    input wire logic cur_valid,
    input wire logic tick_1s,
    output logic trip_alarm,
    output logic trip_loaddump,
    output logic trip_shutdown,
    output logic overcurrent
);
    itd_calc_if calc ();

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic aw_full_q, w_full_q, aw_full_d, w_full_d;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic aw_take, w_take, ar_take, do_write;
    logic [31:0] ctrl_word, wmerge;
    logic wr_ok;

    logic en_q, act_q;
    itd_pkg::itd_rating_t set_q;
    logic [15:0] limit_q [3];
    logic [15:0] tms_q;
    logic [31:0] cool_q;
    logic trip_q, dump_q, shut_q, over_q;
    logic clr_pulse, trip_d;

    function automatic logic [31:0] itd_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write channel: address and data are held independently, then applied together
    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign ar_take = s_axi_arvalid && arready_q;

    always_comb begin
        aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_take);
        w_full_d = do_write ? 1'b0 : (w_full_q || w_take);
        bvalid_d = do_write || (bvalid_q && !s_axi_bready);
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
        rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            rvalid_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            bvalid_q <= bvalid_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            rvalid_q <= rvalid_d;
            arready_q <= arready_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[itd_pkg::ITD_CTRL_EN_BIT] = en_q;
        ctrl_word[itd_pkg::ITD_CTRL_ACT_BIT] = act_q;
        ctrl_word[itd_pkg::ITD_CTRL_SET_LO +: 2] = set_q;
        wmerge = 32'h0000_0000;
        wr_ok = 1'b1;
        case (waddr_q)
            itd_pkg::ITD_OFS_CTRL: wmerge = itd_merge(ctrl_word, wdata_q, wstrb_q);
            itd_pkg::ITD_OFS_LIM_PRI: wmerge = itd_merge({16'h0000, limit_q[0]}, wdata_q, wstrb_q);
            itd_pkg::ITD_OFS_LIM_SEC: wmerge = itd_merge({16'h0000, limit_q[1]}, wdata_q, wstrb_q);
            itd_pkg::ITD_OFS_LIM_TER: wmerge = itd_merge({16'h0000, limit_q[2]}, wdata_q, wstrb_q);
            itd_pkg::ITD_OFS_TMS: wmerge = itd_merge({16'h0000, tms_q}, wdata_q, wstrb_q);
            itd_pkg::ITD_OFS_COOL: wmerge = itd_merge(cool_q, wdata_q, wstrb_q);
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bresp_q <= itd_pkg::ITD_RESP_OKAY;
        end else if (do_write) begin
            bresp_q <= wr_ok ? itd_pkg::ITD_RESP_OKAY : itd_pkg::ITD_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            en_q <= itd_pkg::ITD_RST_EN;
            act_q <= itd_pkg::ITD_RST_ACT;
            set_q <= itd_pkg::ITD_SET_PRI;
            limit_q[0] <= itd_pkg::ITD_RST_LIMIT;
            limit_q[1] <= itd_pkg::ITD_RST_LIMIT;
            limit_q[2] <= itd_pkg::ITD_RST_LIMIT;
            tms_q <= itd_pkg::ITD_RST_TMS;
            cool_q <= itd_pkg::ITD_RST_COOL;
        end else if (do_write) begin
            case (waddr_q)
                itd_pkg::ITD_OFS_CTRL: begin
                    en_q <= wmerge[itd_pkg::ITD_CTRL_EN_BIT];
                    act_q <= wmerge[itd_pkg::ITD_CTRL_ACT_BIT];
                    // Code 3 is not a rating set; it falls back to primary
                    if (wmerge[itd_pkg::ITD_CTRL_SET_LO +: 2] == 2'h3) begin
                        set_q <= itd_pkg::ITD_SET_PRI;
                    end else begin
                        set_q <= itd_pkg::itd_rating_t'(wmerge[itd_pkg::ITD_CTRL_SET_LO +: 2]);
                    end
                end
                itd_pkg::ITD_OFS_LIM_PRI: limit_q[0] <= wmerge[15:0];
                itd_pkg::ITD_OFS_LIM_SEC: limit_q[1] <= wmerge[15:0];
                itd_pkg::ITD_OFS_LIM_TER: limit_q[2] <= wmerge[15:0];
                itd_pkg::ITD_OFS_TMS: tms_q <= wmerge[15:0];
                itd_pkg::ITD_OFS_COOL: cool_q <= wmerge;
                default: begin
                end
            endcase
        end
    end

    // Read channel: data are registered on the address handshake
    always_comb begin
        rdata_d = 32'h0000_0000;
        rresp_d = itd_pkg::ITD_RESP_OKAY;
        case (s_axi_araddr)
            itd_pkg::ITD_OFS_CTRL: rdata_d = ctrl_word;
            itd_pkg::ITD_OFS_LIM_PRI: rdata_d = {16'h0000, limit_q[0]};
            itd_pkg::ITD_OFS_LIM_SEC: rdata_d = {16'h0000, limit_q[1]};
            itd_pkg::ITD_OFS_LIM_TER: rdata_d = {16'h0000, limit_q[2]};
            itd_pkg::ITD_OFS_TMS: rdata_d = {16'h0000, tms_q};
            itd_pkg::ITD_OFS_COOL: rdata_d = cool_q;
            itd_pkg::ITD_OFS_STATUS: begin
                rdata_d[itd_pkg::ITD_STAT_TRIP_BIT] = trip_q;
                rdata_d[itd_pkg::ITD_STAT_DUMP_BIT] = dump_q;
                rdata_d[itd_pkg::ITD_STAT_SHUT_BIT] = shut_q;
                rdata_d[itd_pkg::ITD_STAT_OVER_BIT] = over_q;
            end
            itd_pkg::ITD_OFS_IMAX: rdata_d = {16'h0000, calc.imax};
            itd_pkg::ITD_OFS_HEAT: rdata_d = calc.heat[47:16];
            default: rresp_d = itd_pkg::ITD_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= itd_pkg::ITD_RESP_OKAY;
        end else if (ar_take) begin
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Integrator hookup; the selected rating set steers the live limit
    assign calc.enable = en_q;
    assign calc.tick = tick_1s;
    assign calc.sample = cur_valid;
    assign calc.cur_a = phase_a_cur;
    assign calc.cur_b = phase_b_cur;
    assign calc.cur_c = phase_c_cur;
    assign calc.limit = limit_q[set_q];
    assign calc.tms = tms_q;
    assign calc.cool = cool_q;

    itd_heat u_heat (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .calc(calc)
    );

    // Trip is sticky until software clears it; a new trip in the clear cycle wins
    assign clr_pulse = do_write && (waddr_q == itd_pkg::ITD_OFS_CTRL)
        && wmerge[itd_pkg::ITD_CTRL_CLR_BIT];
    // Guarded by over so a lowered threshold alone cannot trip below the limit
    assign trip_d = (en_q && calc.reached && calc.over)
        || (trip_q && !clr_pulse);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trip_q <= 1'b0;
            dump_q <= 1'b0;
            shut_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            trip_q <= trip_d;
            dump_q <= trip_d && !act_q;
            shut_q <= trip_d && act_q;
            over_q <= en_q && calc.over;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign trip_alarm = trip_q;
    assign trip_loaddump = dump_q;
    assign trip_shutdown = shut_q;
    assign overcurrent = over_q;
endmodule
